// ===== mti_engine.sv
// motion detect and tilt position engine with its register file and first interrupt pin
//
// Overview of operation
// - motion must persist for the delay-counter number of motion-rate samples
// - motion threshold compares acceleration at sixteen counts per g
// - pin control 0x30 enables pin one, active high, latched
// - routing bit value 0x02 sends motion events to pin one
// - main control 0xC2 runs the engine with motion detect enabled
// - persistent motion sets pin, summary bit 4 and motion flag bit 1
// - reading the release register clears latched motion interrupt; host must read
// - after release, pin stays low until a new qualifying event
// - main control 0x41 holds standby with tilt function enabled
// - tilt direction enable per six directions, reset value 0x3F
// - rate control selects tilt rate; 0x98 means 12.5 Hz, reset value
// - new orientation must persist tilt-timer tilt samples before report
// - tilt low limit is sine scaled 32 per g, reset 0x0C
// - tilt high limit bounds upper tilt angle, reset 0x2A
// - hysteresis between orientation states, reset 0x14
// - orientation change sets bits 4 and 0, updates current and previous
// - current orientation readable anytime, one-hot with all directions enabled
// - routing bit value 0x01 sends tilt events to pin one
// - release read also clears tilt interrupt and returns dummy data
// - rate control low field 0x06 selects 50 Hz motion rate
// - motion direction select picks qualifying directions, 0x7F enables all
// - main control top bit selects operate when one, standby when zero
`timescale 1ns/1ps
`include "mti_defines.svh"

module mti_engine #(
    parameter int unsigned BASE_CYC  = `MTI_BASE_CYC,
    parameter int unsigned PULSE_CYC = `MTI_PULSE_CYC
) (
    input  wire logic       mclk,        // system clock, 100 MHz
    input  wire logic       rst,         // asynchronous reset, active high
    input  wire logic [7:0] reg_addr,    // register address
    input  wire logic [7:0] reg_wdata,   // write data
    input  wire logic       reg_wr,      // write strobe, one cycle
    input  wire logic       reg_rd,      // read strobe, one cycle
    output logic      [7:0] reg_rdata,   // read data, valid cycle after strobe
    input  wire logic [7:0] accel_x,     // x acceleration, 64 counts per g
    input  wire logic [7:0] accel_y,     // y acceleration, 64 counts per g
    input  wire logic [7:0] accel_z,     // z acceleration, 64 counts per g
    output logic            irq_pin_one  // first interrupt pin
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // {neg, pos} beyond a 16 counts per g threshold
    function automatic logic [1:0] beyond(input logic [7:0] a,
                                          input logic [7:0] th);
        logic signed [10:0] v;
        logic signed [10:0] t;
        v = 11'(signed'(a));
        t = signed'({1'b0, th, 2'b00});
        beyond = {v < -t, v > t};
    endfunction

    // magnitude rescaled to 32 counts per g
    function automatic logic [7:0] mag32(input logic [7:0] a);
        logic [7:0] m;
        m = a[7] ? 8'(-a) : a;
        mag32 = {1'b0, m[7:1]};
    endfunction

    // rate tick when the low sh prescaler bits are all ones
    function automatic logic rate_hit(input logic [6:0] p,
                                      input logic [2:0] sh);
        logic [6:0] mask;
        mask = 7'((7'h01 << sh) - 7'h01);
        rate_hit = ((p & mask) == mask);
    endfunction

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------

    logic [7:0] main_control_q;
    logic [7:0] tilt_direction_enable_q;
    logic [7:0] function_rate_control_q;
    logic [7:0] irq_pin1_control_q;
    logic [7:0] motion_direction_select_q;
    logic [7:0] irq_pin1_routing_q;
    logic [7:0] tilt_persist_timer_q;
    logic [7:0] motion_delay_counter_q;
    logic [7:0] motion_threshold_q;
    logic [7:0] tilt_low_limit_q;
    logic [7:0] tilt_high_limit_q;
    logic [7:0] orientation_hysteresis_q;

    logic operate;
    logic cfg_wr;
    logic release_rd;

    assign operate    = main_control_q[`MTI_BIT_OPERATE];
    // settings are frozen while operating so a half-written set never runs
    assign cfg_wr     = reg_wr && !operate;
    assign release_rd = reg_rd && (reg_addr == `MTI_OFF_RELEASE);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            main_control_q <= `MTI_RST_MAIN_CTL;
        end else if (reg_wr && reg_addr == `MTI_OFF_MAIN_CTL) begin
            main_control_q <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tilt_direction_enable_q   <= `MTI_RST_TILT_EN;
            function_rate_control_q   <= `MTI_RST_RATE_CTL;
            irq_pin1_control_q        <= `MTI_RST_PIN1_CTL;
            motion_direction_select_q <= `MTI_RST_MOTION_DIR;
            irq_pin1_routing_q        <= `MTI_RST_PIN1_ROUTE;
            tilt_persist_timer_q      <= `MTI_RST_TILT_TIMER;
            motion_delay_counter_q    <= `MTI_RST_MOTION_DLY;
            motion_threshold_q        <= `MTI_RST_MOTION_TH;
            tilt_low_limit_q          <= `MTI_RST_TILT_LL;
            tilt_high_limit_q         <= `MTI_RST_TILT_HL;
            orientation_hysteresis_q  <= `MTI_RST_HYST;
        end else if (cfg_wr) begin
            case (reg_addr)
                `MTI_OFF_TILT_EN:    tilt_direction_enable_q   <= reg_wdata;
                `MTI_OFF_RATE_CTL:   function_rate_control_q   <= reg_wdata;
                `MTI_OFF_PIN1_CTL:   irq_pin1_control_q        <= reg_wdata;
                `MTI_OFF_MOTION_DIR: motion_direction_select_q <= reg_wdata;
                `MTI_OFF_PIN1_ROUTE: irq_pin1_routing_q        <= reg_wdata;
                `MTI_OFF_TILT_TIMER: tilt_persist_timer_q      <= reg_wdata;
                `MTI_OFF_MOTION_DLY: motion_delay_counter_q    <= reg_wdata;
                `MTI_OFF_MOTION_TH:  motion_threshold_q        <= reg_wdata;
                `MTI_OFF_TILT_LL:    tilt_low_limit_q          <= reg_wdata;
                `MTI_OFF_TILT_HL:    tilt_high_limit_q         <= reg_wdata;
                `MTI_OFF_HYST:       orientation_hysteresis_q  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // rate timebase
    // ------------------------------------------------------------

    logic [31:0] base_cnt_q;
    logic [6:0]  pre_q;
    logic        base_tick;
    logic        mot_tick;
    logic        tilt_tick;
    logic [2:0]  tilt_sh;

    assign base_tick = (base_cnt_q == 32'(BASE_CYC - 1));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            base_cnt_q <= 32'h0;
            pre_q      <= 7'h00;
        end else if (!operate) begin
            base_cnt_q <= 32'h0;
            pre_q      <= 7'h00;
        end else if (base_tick) begin
            base_cnt_q <= 32'h0;
            pre_q      <= 7'(pre_q + 7'h01);
        end else begin
            base_cnt_q <= 32'(base_cnt_q + 32'h1);
        end
    end

    // tilt field: 00 1.5625, 01 6.25, 10 12.5, 11 50 Hz off a 100 Hz base
    always_comb begin
        case (function_rate_control_q[7:6])
            2'b00:   tilt_sh = 3'h6;
            2'b01:   tilt_sh = 3'h4;
            2'b10:   tilt_sh = 3'h3;
            default: tilt_sh = 3'h1;
        endcase
    end

    // motion field n gives 100 / 2^(7-n) Hz, so 6 is 50 Hz
    assign mot_tick  = base_tick && rate_hit(pre_q,
                       3'(3'h7 - function_rate_control_q[2:0]));
    assign tilt_tick = base_tick && rate_hit(pre_q, tilt_sh);

    // ------------------------------------------------------------
    // motion detect
    // ------------------------------------------------------------

    mti_pkg::mti_dir_t mot_dirs;
    logic              mot_seen;
    logic [8:0]        mot_cnt_q;
    logic              mot_event;

    assign mot_dirs = {beyond(accel_x, motion_threshold_q),
                       beyond(accel_y, motion_threshold_q),
                       beyond(accel_z, motion_threshold_q)};
    assign mot_seen = |(mot_dirs & motion_direction_select_q[5:0]);
    // one event per episode: the count parks one past the delay
    assign mot_event = mot_tick && mot_seen
                     && main_control_q[`MTI_BIT_MOTION_EN]
                     && (mot_cnt_q == {1'b0, motion_delay_counter_q});

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mot_cnt_q <= 9'h000;
        end else if (!operate || !main_control_q[`MTI_BIT_MOTION_EN]) begin
            mot_cnt_q <= 9'h000;
        end else if (mot_tick) begin
            if (!mot_seen) begin
                mot_cnt_q <= 9'h000;
            end else if (mot_cnt_q <= {1'b0, motion_delay_counter_q}) begin
                mot_cnt_q <= 9'(mot_cnt_q + 9'h001);
            end
        end
    end

    // ------------------------------------------------------------
    // tilt position
    // ------------------------------------------------------------

    logic [7:0]        xs;
    logic [7:0]        ys;
    logic [7:0]        hs;
    logic [7:0]        hy;
    mti_pkg::mti_dir_t cand;
    mti_pkg::mti_dir_t cur_q;
    mti_pkg::mti_dir_t prev_q;
    mti_pkg::mti_dir_t pend_q;
    logic [7:0]        tilt_cnt_q;
    logic              cand_ok;
    logic              tilt_event;

    assign xs = mag32(accel_x);
    assign ys = mag32(accel_y);
    assign hs = (xs > ys) ? xs : ys;
    assign hy = {2'b00, orientation_hysteresis_q[7:2]};

    always_comb begin
        cand = 6'h00;
        if (hs < tilt_low_limit_q) begin
            // near flat: face up or face down
            cand = accel_z[7] ? 6'h02 : 6'h01;
        end else if (hs <= tilt_high_limit_q) begin
            // hysteresis keeps the current axis until the other wins clearly
            if (cur_q[5:4] != 2'b00 && 9'(ys) <= 9'(xs) + 9'(hy)) begin
                cand = accel_x[7] ? 6'h20 : 6'h10;
            end else if (cur_q[3:2] != 2'b00 && 9'(xs) <= 9'(ys) + 9'(hy)) begin
                cand = accel_y[7] ? 6'h08 : 6'h04;
            end else if (xs >= ys) begin
                cand = accel_x[7] ? 6'h20 : 6'h10;
            end else begin
                cand = accel_y[7] ? 6'h08 : 6'h04;
            end
        end
        // above the high limit the reading is not trusted and nothing moves
    end

    assign cand_ok = (cand != 6'h00) && (cand != cur_q)
                   && |(cand & tilt_direction_enable_q[5:0]);
    assign tilt_event = tilt_tick && main_control_q[`MTI_BIT_TILT_EN]
                      && cand_ok && (cand == pend_q)
                      && (tilt_cnt_q >= tilt_persist_timer_q);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pend_q     <= 6'h00;
            tilt_cnt_q <= 8'h00;
        end else if (!operate || !main_control_q[`MTI_BIT_TILT_EN]) begin
            pend_q     <= 6'h00;
            tilt_cnt_q <= 8'h00;
        end else if (tilt_tick) begin
            if (!cand_ok || tilt_event) begin
                pend_q     <= 6'h00;
                tilt_cnt_q <= 8'h00;
            end else if (cand != pend_q) begin
                pend_q     <= cand;
                tilt_cnt_q <= 8'h01;
            end else if (tilt_cnt_q != 8'hff) begin
                tilt_cnt_q <= 8'(tilt_cnt_q + 8'h01);
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cur_q  <= 6'h01;
            prev_q <= 6'h00;
        end else if (tilt_event) begin
            prev_q <= cur_q;
            cur_q  <= cand;
        end
    end

    // ------------------------------------------------------------
    // event flags and pin one
    // ------------------------------------------------------------

    logic                   mot_flag_q;
    logic                   tilt_flag_q;
    logic                   pin_level;
    logic                   route_evt;
    logic                   pol;
    logic [15:0]            pulse_cnt_q;
    mti_pkg::mti_pin_state_t pin_st_q;

    // a new event beats a release read in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mot_flag_q  <= 1'b0;
            tilt_flag_q <= 1'b0;
        end else begin
            mot_flag_q  <= mot_event || (mot_flag_q && !release_rd);
            tilt_flag_q <= tilt_event || (tilt_flag_q && !release_rd);
        end
    end

    assign pin_level = (irq_pin1_routing_q[`MTI_BIT_ROUTE_MOT] && mot_flag_q)
                    || (irq_pin1_routing_q[`MTI_BIT_ROUTE_TILT] && tilt_flag_q);
    assign route_evt = (irq_pin1_routing_q[`MTI_BIT_ROUTE_MOT] && mot_event)
                    || (irq_pin1_routing_q[`MTI_BIT_ROUTE_TILT] && tilt_event);
    assign pol       = irq_pin1_control_q[`MTI_BIT_PIN_POL];

    // pulse mode stretches a routed event that arrives in idle to a fixed width; events during a running pulse are absorbed
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_st_q    <= mti_pkg::MTI_PIN_IDLE;
            pulse_cnt_q <= 16'h0000;
        end else begin
            case (pin_st_q)
                mti_pkg::MTI_PIN_IDLE: begin
                    if (route_evt) begin
                        pin_st_q    <= mti_pkg::MTI_PIN_PULSE;
                        pulse_cnt_q <= 16'(PULSE_CYC - 1);
                    end
                end
                mti_pkg::MTI_PIN_PULSE: begin
                    if (pulse_cnt_q == 16'h0000) begin
                        pin_st_q <= mti_pkg::MTI_PIN_IDLE;
                    end else begin
                        pulse_cnt_q <= 16'(pulse_cnt_q - 16'h0001);
                    end
                end
                default: pin_st_q <= mti_pkg::MTI_PIN_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_pin_one <= 1'b0;
        end else if (!irq_pin1_control_q[`MTI_BIT_PIN_EN]) begin
            irq_pin_one <= !pol;
        end else if (irq_pin1_control_q[`MTI_BIT_PIN_PULSE]) begin
            irq_pin_one <= (pin_st_q == mti_pkg::MTI_PIN_PULSE) ~^ pol;
        end else begin
            irq_pin_one <= pin_level ~^ pol;
        end
    end

    // ------------------------------------------------------------
    // read side
    // ------------------------------------------------------------

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `MTI_OFF_CUR_ORIENT:  reg_rdata <= {2'b00, cur_q};
                `MTI_OFF_PREV_ORIENT: reg_rdata <= {2'b00, prev_q};
                `MTI_OFF_SRC_TWO:     reg_rdata <= {6'h00, mot_flag_q, tilt_flag_q};
                `MTI_OFF_STATUS:
                    reg_rdata <= {3'b000, mot_flag_q || tilt_flag_q, 4'h0};
                `MTI_OFF_RELEASE:     reg_rdata <= 8'h00;
                `MTI_OFF_MAIN_CTL:    reg_rdata <= main_control_q;
                `MTI_OFF_TILT_EN:     reg_rdata <= tilt_direction_enable_q;
                `MTI_OFF_RATE_CTL:    reg_rdata <= function_rate_control_q;
                `MTI_OFF_PIN1_CTL:    reg_rdata <= irq_pin1_control_q;
                `MTI_OFF_MOTION_DIR:  reg_rdata <= motion_direction_select_q;
                `MTI_OFF_PIN1_ROUTE:  reg_rdata <= irq_pin1_routing_q;
                `MTI_OFF_TILT_TIMER:  reg_rdata <= tilt_persist_timer_q;
                `MTI_OFF_MOTION_DLY:  reg_rdata <= motion_delay_counter_q;
                `MTI_OFF_MOTION_TH:   reg_rdata <= motion_threshold_q;
                `MTI_OFF_TILT_LL:     reg_rdata <= tilt_low_limit_q;
                `MTI_OFF_TILT_HL:     reg_rdata <= tilt_high_limit_q;
                `MTI_OFF_HYST:        reg_rdata <= orientation_hysteresis_q;
                default:              reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// ===== mti_defines.svh
// offsets, field positions, reset values and timing counts of the motion and tilt engine
`ifndef MTI_DEFINES_SVH
`define MTI_DEFINES_SVH

`define MTI_OFF_CUR_ORIENT  8'h10
`define MTI_OFF_PREV_ORIENT 8'h11
`define MTI_OFF_SRC_TWO     8'h13
`define MTI_OFF_STATUS      8'h15
`define MTI_OFF_RELEASE     8'h17
`define MTI_OFF_MAIN_CTL    8'h18
`define MTI_OFF_TILT_EN     8'h19
`define MTI_OFF_RATE_CTL    8'h1a
`define MTI_OFF_PIN1_CTL    8'h1c
`define MTI_OFF_MOTION_DIR  8'h1d
`define MTI_OFF_PIN1_ROUTE  8'h1f
`define MTI_OFF_TILT_TIMER  8'h22
`define MTI_OFF_MOTION_DLY  8'h23
`define MTI_OFF_MOTION_TH   8'h30
`define MTI_OFF_TILT_LL     8'h32
`define MTI_OFF_TILT_HL     8'h33
`define MTI_OFF_HYST        8'h34

`define MTI_RST_MAIN_CTL    8'h00
`define MTI_RST_TILT_EN     8'h3f
`define MTI_RST_RATE_CTL    8'h98
`define MTI_RST_PIN1_CTL    8'h10
`define MTI_RST_MOTION_DIR  8'h3f
`define MTI_RST_PIN1_ROUTE  8'h00
`define MTI_RST_TILT_TIMER  8'h00
`define MTI_RST_MOTION_DLY  8'h00
`define MTI_RST_MOTION_TH   8'h08
`define MTI_RST_TILT_LL     8'h0c
`define MTI_RST_TILT_HL     8'h2a
`define MTI_RST_HYST        8'h14

`define MTI_BIT_OPERATE     7
`define MTI_BIT_MOTION_EN   1
`define MTI_BIT_TILT_EN     0
`define MTI_BIT_PIN_EN      5
`define MTI_BIT_PIN_POL     4
`define MTI_BIT_PIN_PULSE   3
`define MTI_BIT_ROUTE_MOT   1
`define MTI_BIT_ROUTE_TILT  0
`define MTI_BIT_SUMMARY     4
`define MTI_BIT_MOT_FLAG    1
`define MTI_BIT_TILT_FLAG   0

`define MTI_CLK_HZ          100000000
`define MTI_BASE_HZ         100
`define MTI_BASE_CYC        (`MTI_CLK_HZ / `MTI_BASE_HZ)
`define MTI_PULSE_NS        30000
`define MTI_PULSE_CYC       ((`MTI_PULSE_NS + 9) / 10)

`endif

// ===== mti_pkg.sv
// types shared by the motion and tilt engine
package mti_pkg;

    typedef logic [5:0] mti_dir_t;

    typedef enum logic [0:0] {
        MTI_PIN_IDLE  = 1'b0,
        MTI_PIN_PULSE = 1'b1
    } mti_pin_state_t;

endpackage

// ===== mti_engine_chk.sv
// port assertions for the motion and tilt engine
`timescale 1ns/1ps
module mti_engine_chk (
    input wire logic       mclk,        // clock
    input wire logic       rst,         // async reset
    input wire logic [7:0] reg_addr,    // address
    input wire logic [7:0] reg_wdata,   // write data
    input wire logic       reg_wr,      // write strobe
    input wire logic       reg_rd,      // read strobe
    input wire logic [7:0] reg_rdata,   // read data
    input wire logic [7:0] accel_x,     // x sample
    input wire logic [7:0] accel_y,     // y sample
    input wire logic [7:0] accel_z,     // z sample
    input wire logic       irq_pin_one  // pin one
);
    // ----
    // shadows of accepted settings
    // ----
    logic [7:0] ctl_q, rte_q, th_q, ten_q;
    logic       op_q;
    logic [1:0] age_q;
    logic [5:0] st_q;
    logic       big;
    logic       wok;

    function automatic logic [9:0] mag(input logic [7:0] v);
        return {2'b00, v[7] ? -v : v};
    endfunction

    // settings other than main control only land in standby
    assign wok = reg_wr && !op_q;
    assign big = mag(accel_x) > {th_q, 2'b00} || mag(accel_y) > {th_q, 2'b00}
              || mag(accel_z) > {th_q, 2'b00};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) op_q <= 1'b0;
        else if (reg_wr && reg_addr == 8'h18) op_q <= reg_wdata[7];
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctl_q <= 8'h10;
            rte_q <= 8'h00;
            th_q  <= 8'h08;
            ten_q <= 8'h3f;
        end else if (wok) begin
            if (reg_addr == 8'h1c) ctl_q <= reg_wdata;
            if (reg_addr == 8'h1f) rte_q <= reg_wdata;
            if (reg_addr == 8'h30) th_q <= reg_wdata;
            if (reg_addr == 8'h19) ten_q <= reg_wdata;
        end
    end
    // pin checks wait out the two-edge lag after a pin setting changes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) age_q <= 2'd0;
        else if (wok && (reg_addr == 8'h1c || reg_addr == 8'h1f)) age_q <= 2'd0;
        else if (age_q != 2'd3) age_q <= age_q + 2'd1;
    end
    // a long still input means no detector is mid-count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) st_q <= 6'd0;
        else if ($stable(accel_x) && $stable(accel_y) && $stable(accel_z))
            st_q <= st_q + {5'd0, st_q != 6'h3f};
        else st_q <= 6'd0;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_rel_zero;
        reg_rd && reg_addr == 8'h17 |=> reg_rdata == 8'h00;
    endproperty
    a_rel_zero: assert property (p_rel_zero) else $error("release data not zero");
    property p_rel_drop;
        irq_pin_one && ctl_q == 8'h30 && st_q == 6'h3f && reg_rd && reg_addr == 8'h17
            |-> ##2 !irq_pin_one;
    endproperty
    a_rel_drop: assert property (p_rel_drop) else $error("pin kept after release");
    property p_latch_hold;
        $fell(irq_pin_one) && ctl_q == 8'h30 && age_q == 2'd3
            |-> $past(reg_rd && reg_addr == 8'h17, 2);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("pin fell unasked");
    property p_rise_op;
        $rose(irq_pin_one) && ctl_q == 8'h30 && age_q == 2'd3 |-> $past(op_q, 2);
    endproperty
    a_rise_op: assert property (p_rise_op) else $error("event in standby");
    property p_route_mot;
        $rose(irq_pin_one) && ctl_q == 8'h30 && age_q == 2'd3 && rte_q == 8'h02
            |-> $past(big, 2);
    endproperty
    a_route_mot: assert property (p_route_mot) else $error("motion below level");
    property p_no_route;
        ctl_q == 8'h30 && age_q == 2'd3 && rte_q == 8'h00 |-> !irq_pin_one;
    endproperty
    a_no_route: assert property (p_no_route) else $error("unrouted pin high");
    property p_pin_off;
        ctl_q[5:4] == 2'b01 && age_q == 2'd3 |-> !irq_pin_one;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("disabled pin active");
    property p_onehot;
        reg_rd && reg_addr == 8'h10 && ten_q == 8'h3f |=> $onehot(reg_rdata);
    endproperty
    a_onehot: assert property (p_onehot) else $error("orientation not one-hot");

    c_mot: cover property ($rose(irq_pin_one) && rte_q == 8'h02);
    c_tilt: cover property ($rose(irq_pin_one) && rte_q == 8'h01);
    c_rel: cover property (irq_pin_one && st_q == 6'h3f && reg_rd && reg_addr == 8'h17);
endmodule

bind mti_engine mti_engine_chk i_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z), .irq_pin_one(irq_pin_one));

// ===== mti_host.sv
// host model driving the engine register port
`timescale 1ns/1ps
module mti_host (
    input  wire logic       mclk,       // clock
    output logic      [7:0] reg_addr,   // address
    output logic      [7:0] reg_wdata,  // write data
    output logic            reg_wr,     // write strobe
    output logic            reg_rd,     // read strobe
    input  wire logic [7:0] reg_rdata   // read data
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // idle lines carry inverted leftovers so nothing leans on stale values
    // callers change settings in standby, then return to operate; one write while operating checks that it is refused
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // a read of the release place is how the host frees the pin
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

// ===== mti_engine_test.sv
// self-checking bench for the motion and tilt engine
`timescale 1ns/1ps
module mti_engine_test;
    logic       mclk;          // clock
    logic       rst;           // reset
    logic [7:0] reg_addr;      // address
    logic [7:0] reg_wdata;     // write data
    logic       reg_wr;        // write strobe
    logic       reg_rd;        // read strobe
    logic [7:0] reg_rdata;     // read data
    logic [7:0] ax, ay, az;    // acceleration
    logic       irq;           // pin one
    int         bad_count;
    int         total_checks;
    int         i;
    logic [7:0] ra [7] = '{8'h19, 8'h1a, 8'h32, 8'h33, 8'h34, 8'h10, 8'h00};
    logic [7:0] rv [7] = '{8'h3f, 8'h98, 8'h0c, 8'h2a, 8'h14, 8'h01, 8'h00};
    logic [7:0] ma [8] = '{8'h18, 8'h1a, 8'h1d, 8'h23, 8'h30, 8'h1c, 8'h1f, 8'h18};
    logic [7:0] mv [8] = '{8'h42, 8'h06, 8'h7f, 8'h05, 8'h08, 8'h30, 8'h02, 8'hc2};
    logic [7:0] ta [6] = '{8'h18, 8'h19, 8'h1a, 8'h22, 8'h1f, 8'h18};
    logic [7:0] tv [6] = '{8'h41, 8'h3f, 8'h98, 8'h01, 8'h01, 8'hc1};

    // short base tick keeps rate ticks at a few cycles
    mti_engine #(.BASE_CYC(4), .PULSE_CYC(4)) i_dut (.mclk(mclk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .accel_x(ax), .accel_y(ay), .accel_z(az),
        .irq_pin_one(irq));
    mti_host i_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    always #5 mclk = ~mclk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        check(d, exp);
    endtask
    // waits at most n cycles for the pin level, then compares
    task automatic pin_is(input logic v, input int n);
        int k;
        for (k = 0; k < n && irq !== v; k++) @(negedge mclk);
        check({7'd0, irq}, {7'd0, v});
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        ax = 8'h00;
        ay = 8'h00;
        az = 8'h00;
        bad_count = 0;
        total_checks = 0;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        for (i = 0; i < 7; i++) rd_chk(ra[i], rv[i]);
        for (i = 0; i < 8; i++) i_host.wr(ma[i], mv[i]);
        ax = 8'h20;
        repeat (100) @(negedge mclk);
        pin_is(1'b0, 0);
        ax = 8'h21;
        repeat (32) @(negedge mclk);
        pin_is(1'b0, 0);
        pin_is(1'b1, 40);
        rd_chk(8'h13, 8'h02);
        rd_chk(8'h15, 8'h10);
        repeat (64) @(negedge mclk);
        pin_is(1'b1, 0);
        rd_chk(8'h17, 8'h00);
        pin_is(1'b0, 2);
        repeat (60) @(negedge mclk);
        pin_is(1'b0, 0);
        rd_chk(8'h13, 8'h00);
        ax = 8'h00;
        repeat (20) @(negedge mclk);
        ax = 8'hd8;
        pin_is(1'b1, 80);
        repeat (70) @(negedge mclk);
        rd_chk(8'h17, 8'h00);
        pin_is(1'b0, 2);
        ax = 8'h00;
        az = 8'h40;
        for (i = 0; i < 6; i++) i_host.wr(ta[i], tv[i]);
        ax = 8'h40;
        az = 8'h00;
        pin_is(1'b1, 80);
        rd_chk(8'h10, 8'h10);
        rd_chk(8'h11, 8'h01);
        rd_chk(8'h13, 8'h01);
        rd_chk(8'h15, 8'h10);
        repeat (70) @(negedge mclk);
        rd_chk(8'h17, 8'h00);
        pin_is(1'b0, 2);
        i_host.wr(8'h22, 8'h07);
        rd_chk(8'h22, 8'h01);
        i_host.wr(8'h18, 8'h01);
        i_host.wr(8'h1f, 8'h00);
        repeat (4) @(negedge mclk);
        pin_is(1'b0, 0);
        ax = 8'hc0;
        i_host.wr(8'h1c, 8'h38);
        i_host.wr(8'h1f, 8'h01);
        i_host.wr(8'h18, 8'hc1);
        pin_is(1'b1, 80);
        repeat (4) @(negedge mclk);
        pin_is(1'b0, 0);
        rd_chk(8'h13, 8'h01);
        summarize();
    end

    // the sequence needs under a thousand cycles; ten thousand means a hang
    initial begin
        #100000;
        bad_count++;
        summarize();
    end
endmodule
